// *** vsm_consts.vh ***
// Constants for the sync monitor and rate 1/2 input alignment block
`ifndef VSM_CONSTS_VH
`define VSM_CONSTS_VH
`define VSM_CNT_W        8
`define VSM_WORD_W       3
`define VSM_BIT_PRESCALE 8'h00
`define VSM_NRM_PRESCALE 3'h7
`define VSM_NRM_W        3
`define VSM_NRM_RELOAD   3'h3
`define VSM_RST_PERIOD   8'hFE
`define VSM_RST_BUDGET   8'hF9
`define VSM_MODE_BIT     3
`define VSM_CTRL_W       8
`endif

// *** vsm_rate_monitor.v ***
// Normalization rate monitor with period and budget counters
`timescale 1ns/100ps
`include "vsm_consts.vh"
module vsm_rate_monitor (
  input  wire                    clk,
  input  wire                    reset,
  input  wire                    bit_done,
  input  wire                    norm_event,
  input  wire [`VSM_CNT_W-1:0]   period_load,
  input  wire [`VSM_CNT_W-1:0]   budget_load,
  output reg                     sync_lost_q,
  output reg                     sync_held_q
);
  reg [`VSM_CNT_W-1:0] pre_q;
  reg [`VSM_CNT_W-1:0] period_q;
  reg [`VSM_NRM_W-1:0] npre_q;
  reg [`VSM_CNT_W-1:0] budget_q;
  reg                  over_q;
  wire                 pre_wrap;
  wire                 period_end;
  wire                 npre_wrap;

  // Bit prescale by 256, normalization prescale by 8
  assign pre_wrap   = bit_done && (pre_q == 8'hFF);
  assign period_end = pre_wrap && (period_q == 8'hFF);
  assign npre_wrap  = norm_event && (npre_q == `VSM_NRM_PRESCALE);

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pre_q       <= `VSM_BIT_PRESCALE;
      period_q    <= `VSM_RST_PERIOD;
      npre_q      <= `VSM_NRM_RELOAD;
      budget_q    <= `VSM_RST_BUDGET;
      over_q      <= 1'b0;
      sync_lost_q <= 1'b0;
      sync_held_q <= 1'b1;
    end else begin
      if (bit_done) begin
        pre_q <= pre_q + 8'h01;
      end
      if (period_end) begin
        // Verdict for the period, then reload both counters
        sync_lost_q <= over_q || npre_wrap && (budget_q == 8'hFF);
        sync_held_q <= !(over_q || npre_wrap && (budget_q == 8'hFF));
        period_q    <= period_load;
        budget_q    <= budget_load;
        // Start at 3 so overflow lands on normalization (N-1)*8+5
        npre_q      <= `VSM_NRM_RELOAD;
        over_q      <= 1'b0;
      end else begin
        if (pre_wrap) begin
          // Counts up from the two's complement load
          period_q <= period_q + 8'h01;
        end
        if (norm_event) begin
          npre_q <= npre_q + 3'h1;
        end
        if (npre_wrap) begin
          if (budget_q == 8'hFF) begin
            over_q <= 1'b1;
          end
          budget_q <= budget_q + 8'h01;
        end
      end
    end
  end
endmodule // vsm_rate_monitor

// *** vsm_pair_align.v ***
// Rate 1/2 input alignment: parallel swap/invert and serial pairing
`timescale 1ns/100ps
`include "vsm_consts.vh"
module vsm_pair_align (
  input  wire                    clk,
  input  wire                    reset,
  input  wire                    in_clk_en,
  input  wire                    serial_mode,
  input  wire                    oqpsk_mode,
  input  wire                    step,
  input  wire                    use_marker,
  input  wire                    first_word_marker_n,
  input  wire [`VSM_WORD_W-1:0]  word0_in,
  input  wire [`VSM_WORD_W-1:0]  word1_in,
  output reg  [`VSM_WORD_W-1:0]  int_word0_q,
  output reg  [`VSM_WORD_W-1:0]  int_word1_q,
  output reg                     pair_valid_q,
  output reg                     alt_state_q
);
  reg [`VSM_WORD_W-1:0] w1_dly_q;
  reg [`VSM_WORD_W-1:0] held_q;
  reg                   phase_q;
  reg                   halt_q;
  wire [`VSM_WORD_W-1:0] w1_use;

  // Bitwise one's complement inversion of every bit of a soft word
  function [`VSM_WORD_W-1:0] vsm_invert;
    input [`VSM_WORD_W-1:0] w;
    begin
      vsm_invert = ~w;
    end
  endfunction

  assign w1_use = oqpsk_mode ? w1_dly_q : word1_in;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      int_word0_q  <= 3'h0;
      int_word1_q  <= 3'h0;
      pair_valid_q <= 1'b0;
      alt_state_q  <= 1'b0;
      w1_dly_q     <= 3'h0;
      held_q       <= 3'h0;
      phase_q      <= 1'b0;
      halt_q       <= 1'b0;
    end else begin
      pair_valid_q <= 1'b0;
      if (step && !serial_mode) begin
        alt_state_q <= ~alt_state_q;
      end
      if (step && serial_mode) begin
        halt_q <= 1'b1;
      end
      if (in_clk_en) begin
        w1_dly_q <= word1_in;
        if (!serial_mode) begin
          pair_valid_q <= 1'b1;
          if (alt_state_q) begin
            // Swap words and invert first input word
            int_word0_q <= w1_use;
            int_word1_q <= vsm_invert(word0_in);
          end else begin
            int_word0_q <= word0_in;
            int_word1_q <= word1_in;
          end
        end else if (use_marker) begin
          // Marker drives pairing directly
          if (!first_word_marker_n) begin
            held_q  <= word0_in;
            phase_q <= 1'b1;
          end else if (phase_q) begin
            int_word0_q  <= held_q;
            int_word1_q  <= word0_in;
            pair_valid_q <= 1'b1;
            phase_q      <= 1'b0;
          end
        end else if (halt_q || step) begin
          halt_q <= 1'b0; // One period stall slips pairing
        end else if (!phase_q) begin
          held_q  <= word0_in;
          phase_q <= 1'b1;
        end else begin
          // Pairing only, no phase correction
          int_word0_q  <= held_q;
          int_word1_q  <= word0_in;
          pair_valid_q <= 1'b1;
          phase_q      <= 1'b0;
        end
      end
    end
  end
endmodule // vsm_pair_align

// *** vsm_sync_front.v ***
// Decoder sync front end: data mode select, alignment and rate monitor
`timescale 1ns/100ps
`include "vsm_consts.vh"
module vsm_sync_front (
  input  wire                    clk,
  input  wire                    reset,
  input  wire [`VSM_CTRL_W-1:0]  enc_ctrl2,
  input  wire [`VSM_CTRL_W-1:0]  dec_ctrl2,
  input  wire [1:0]              enc_rate_sel,
  input  wire [1:0]              dec_rate_sel,
  input  wire                    serial_mode,
  input  wire                    oqpsk_mode,
  input  wire                    diff_enable,
  input  wire                    use_marker,
  input  wire [`VSM_CNT_W-1:0]   period_load,
  input  wire [`VSM_CNT_W-1:0]   budget_load,
  input  wire                    sync_step_request,
  input  wire                    norm_event,
  input  wire                    decoded_bit,
  input  wire                    decoded_bit_valid,
  input  wire                    decoder_input_clock,
  input  wire                    decoder_output_clock,
  input  wire                    decoder_reset,
  input  wire                    first_word_marker_n,
  input  wire [`VSM_WORD_W-1:0]  received_word_0,
  input  wire [`VSM_WORD_W-1:0]  received_word_1,
  input  wire                    periph_in_strobe,
  input  wire                    periph_out_strobe,
  input  wire                    periph_reset_strobe,
  input  wire [`VSM_WORD_W-1:0]  periph_word_0,
  input  wire [`VSM_WORD_W-1:0]  periph_word_1,
  output reg  [`VSM_WORD_W-1:0]  int_word0_q,
  output reg  [`VSM_WORD_W-1:0]  int_word1_q,
  output reg                     pair_valid_q,
  output reg                     alt_state_q,
  output reg                     out_strobe_q,
  output reg                     decoded_out_q,
  output reg  [1:0]              enc_rate_q,
  output reg  [1:0]              dec_rate_q,
  output reg                     periph_mode_q,
  output reg                     sync_lost_flag,
  output reg                     sync_held_flag
);
  wire                   periph;
  wire                   in_en;
  wire                   soft_reset;
  wire [`VSM_WORD_W-1:0] w0_sel;
  wire [`VSM_WORD_W-1:0] w1_sel;
  wire [`VSM_WORD_W-1:0] a_w0;
  wire [`VSM_WORD_W-1:0] a_w1;
  wire                   a_valid;
  wire                   a_alt;
  wire                   m_lost;
  wire                   m_held;
  reg                    dclk_q;
  reg                    oclk_q;
  reg                    diff_prev_q;
  reg                    blk_reset_q;

  // Peripheral only when both control words select it
  assign periph = enc_ctrl2[`VSM_MODE_BIT] && dec_ctrl2[`VSM_MODE_BIT];

  // Data, clocks and reset taken from strobes instead of pins
  assign in_en  = periph ? periph_in_strobe : (decoder_input_clock && !dclk_q);
  assign w0_sel = periph ? periph_word_0 : received_word_0;
  assign w1_sel = periph ? periph_word_1 : received_word_1;
  assign soft_reset = periph ? periph_reset_strobe : decoder_reset;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      dclk_q      <= 1'b0;
      oclk_q      <= 1'b0;
      blk_reset_q <= 1'b0;
    end else begin
      dclk_q      <= decoder_input_clock;
      oclk_q      <= decoder_output_clock;
      blk_reset_q <= soft_reset;
    end
  end

  vsm_pair_align u_align (
    .clk                 (clk),
    .reset               (reset),
    .in_clk_en           (in_en),
    .serial_mode         (serial_mode),
    .oqpsk_mode          (oqpsk_mode),
    .step                (sync_step_request),
    .use_marker          (use_marker),
    .first_word_marker_n (first_word_marker_n),
    .word0_in            (w0_sel),
    .word1_in            (w1_sel),
    .int_word0_q         (a_w0),
    .int_word1_q         (a_w1),
    .pair_valid_q        (a_valid),
    .alt_state_q         (a_alt)
  );

  vsm_rate_monitor u_mon (
    .clk         (clk),
    .reset       (reset),
    .bit_done    (decoded_bit_valid),
    .norm_event  (norm_event),
    .period_load (period_load),
    .budget_load (budget_load),
    .sync_lost_q (m_lost),
    .sync_held_q (m_held)
  );

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      int_word0_q    <= 3'h0;
      int_word1_q    <= 3'h0;
      pair_valid_q   <= 1'b0;
      alt_state_q    <= 1'b0;
      out_strobe_q   <= 1'b0;
      decoded_out_q  <= 1'b0;
      diff_prev_q    <= 1'b0;
      enc_rate_q     <= 2'h0;
      dec_rate_q     <= 2'h0;
      periph_mode_q  <= 1'b0;
      sync_lost_flag <= 1'b0;
      sync_held_flag <= 1'b1;
    end else begin
      int_word0_q    <= a_w0;
      int_word1_q    <= a_w1;
      pair_valid_q   <= a_valid && !blk_reset_q;
      alt_state_q    <= a_alt;
      sync_lost_flag <= m_lost;
      sync_held_flag <= m_held;
      periph_mode_q  <= periph;
      enc_rate_q     <= enc_rate_sel;
      dec_rate_q     <= dec_rate_sel;
      out_strobe_q   <= periph ? periph_out_strobe : (decoder_output_clock && !oclk_q);
      if (blk_reset_q) begin
        diff_prev_q   <= 1'b0;
        decoded_out_q <= 1'b0;
      end else if (decoded_bit_valid) begin
        // Differential decode removes a whole-stream inversion
        diff_prev_q   <= decoded_bit;
        decoded_out_q <= diff_enable ? (decoded_bit ^ diff_prev_q) : decoded_bit;
      end
    end
  end
endmodule // vsm_sync_front

// *** vsm_sync_front_props.sv ***
// Checker for the sync front end flags, alignment strobes and mode select
`timescale 1ns/100ps
`include "vsm_consts.vh"
module vsm_sync_front_props (
  input logic                   clk,
  input logic                   reset,
  input logic [`VSM_CTRL_W-1:0] enc_ctrl2,
  input logic [`VSM_CTRL_W-1:0] dec_ctrl2,
  input logic [1:0]             enc_rate_sel,
  input logic [1:0]             dec_rate_sel,
  input logic                   serial_mode,
  input logic                   sync_step_request,
  input logic                   decoder_input_clock,
  input logic                   decoder_output_clock,
  input logic                   periph_in_strobe,
  input logic                   periph_out_strobe,
  input logic                   pair_valid_q,
  input logic                   alt_state_q,
  input logic                   out_strobe_q,
  input logic [1:0]             enc_rate_q,
  input logic [1:0]             dec_rate_q,
  input logic                   periph_mode_q,
  input logic                   sync_lost_flag,
  input logic                   sync_held_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_FLAG_EXCL: assert property (sync_lost_flag != sync_held_flag)
    else $error("lost and held flags agree");
  AST_ALT_TOG: assert property (!serial_mode && sync_step_request |=> ##1
    alt_state_q != $past(alt_state_q)) else $error("step did not toggle state");
  AST_ALT_HOLD: assert property (!sync_step_request && !$past(sync_step_request) |=>
    $stable(alt_state_q)) else $error("state moved without step");
  AST_RATES: assert property (1'b1 |=> enc_rate_q == $past(enc_rate_sel) &&
    dec_rate_q == $past(dec_rate_sel)) else $error("rate codes not independent");
  AST_PMODE: assert property (1'b1 |=> periph_mode_q ==
    $past(enc_ctrl2[`VSM_MODE_BIT] & dec_ctrl2[`VSM_MODE_BIT])) else $error("mode select");
  AST_PAIR_DIR: assert property (!serial_mode && !periph_mode_q &&
    $rose(decoder_input_clock) |-> ##[1:4] pair_valid_q) else $error("no pair");
  AST_PAIR_PER: assert property (!serial_mode && periph_mode_q && periph_in_strobe
    |-> ##[1:3] pair_valid_q) else $error("no pair from strobe");
  AST_OUT_DIR: assert property (!periph_mode_q && $rose(decoder_output_clock)
    |-> ##[1:3] out_strobe_q) else $error("no output strobe");
  AST_OUT_PER: assert property (periph_mode_q && periph_out_strobe
    |-> ##[1:3] out_strobe_q) else $error("no written output strobe");
endmodule // vsm_sync_front_props
bind vsm_sync_front vsm_sync_front_props vsm_sync_front_props_inst (.clk, .reset,
  .enc_ctrl2, .dec_ctrl2, .enc_rate_sel, .dec_rate_sel, .serial_mode, .sync_step_request,
  .decoder_input_clock, .decoder_output_clock, .periph_in_strobe, .periph_out_strobe,
  .pair_valid_q, .alt_state_q, .out_strobe_q, .enc_rate_q, .dec_rate_q, .periph_mode_q,
  .sync_lost_flag, .sync_held_flag);

// *** vsm_demod_model.sv ***
// Demodulator model: code words, first word marker and decoder input clock
`timescale 1ns/100ps
`include "vsm_consts.vh"
module vsm_demod_model (
  input  logic                  clk,
  output logic                  decoder_input_clock = 1'b0,
  output logic                  first_word_marker_n = 1'b0,
  output logic [`VSM_WORD_W-1:0] received_word_0 = '0,
  output logic [`VSM_WORD_W-1:0] received_word_1 = '0
);
  // One input period; afterwards the words no longer hold their value
  task automatic send(input logic [`VSM_WORD_W-1:0] a, b, input logic m, input int gap);
    @(posedge clk);
    received_word_0     <= a;
    received_word_1     <= b;
    first_word_marker_n <= m;
    decoder_input_clock <= 1'b1;
    repeat (2) @(posedge clk);
    decoder_input_clock <= 1'b0;
    repeat (2) @(posedge clk);
    received_word_0     <= ~a;
    received_word_1     <= ~b;
    first_word_marker_n <= ~m;
    repeat (gap) @(posedge clk);
  endtask
  task automatic park;
    @(posedge clk);
    received_word_0     <= '0;
    received_word_1     <= '0;
    first_word_marker_n <= 1'b0;
  endtask
endmodule // vsm_demod_model

// *** vsm_sync_front_tb_top.sv ***
// Testbench for the decoder sync front end
`timescale 1ns/100ps
`include "vsm_consts.vh"
module vsm_sync_front_tb_top;
  logic       clk, reset, serial_mode, oqpsk_mode, use_marker, sync_step_request;
  logic       norm_event, decoded_bit, decoded_bit_valid, decoder_output_clock;
  logic       periph_in_strobe, periph_out_strobe, pair_valid_q, alt, diff_enable, decoded_out_q;
  logic       decoder_input_clock, first_word_marker_n, sync_lost_flag, sync_held_flag;
  logic [7:0] enc_ctrl2, dec_ctrl2;
  logic [1:0] enc_rate_sel, dec_rate_sel;
  logic [2:0] periph_word_0, periph_word_1, received_word_0, received_word_1, pw1;
  logic [2:0] int_word0_q, int_word1_q;
  logic [31:0] rnd;
  logic [5:0] exp_q[$];
  int         errors, checks;
  vsm_demod_model dm (.clk, .decoder_input_clock, .first_word_marker_n,
    .received_word_0, .received_word_1);
  vsm_sync_front vsm_sync_front_inst (.clk, .reset, .enc_ctrl2, .dec_ctrl2,
    .enc_rate_sel, .dec_rate_sel, .serial_mode, .oqpsk_mode, .diff_enable,
    .use_marker, .period_load(8'hFE), .budget_load(8'hF9), .sync_step_request,
    .norm_event, .decoded_bit, .decoded_bit_valid, .decoder_input_clock,
    .decoder_output_clock, .decoder_reset(1'b0), .first_word_marker_n,
    .received_word_0, .received_word_1, .periph_in_strobe, .periph_out_strobe,
    .periph_reset_strobe(1'b0), .periph_word_0, .periph_word_1, .int_word0_q,
    .int_word1_q, .pair_valid_q, .alt_state_q(), .out_strobe_q(), .decoded_out_q,
    .enc_rate_q(), .dec_rate_q(), .periph_mode_q(), .sync_lost_flag, .sync_held_flag);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input logic [5:0] got, exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Expected pair for the current state, noted before the words go out
  task automatic note(input logic [2:0] a, b, input logic oq);
    exp_q.push_back(alt ? {oq ? pw1 : b, ~a} : {a, b});
    pw1 = b;
  endtask
  task automatic par(input logic oq);
    rnd = lfsr(rnd);
    note(rnd[2:0], rnd[5:3], oq);
    dm.send(rnd[2:0], rnd[5:3], 1'b1, rnd[6] ? 6 : 1);
  endtask
  task automatic step;
    @(posedge clk);
    sync_step_request <= 1'b1;
    @(posedge clk);
    sync_step_request <= 1'b0;
    repeat (3) @(posedge clk);
    if (!serial_mode) alt = !alt;
  endtask
  task automatic mon(input int n, input logic lost);
    for (int i = 0; i < 1024; i++) begin
      @(posedge clk);
      decoded_bit_valid <= (i % 2 == 0);
      decoded_bit       <= rnd[i % 32];
      norm_event        <= (i % 4 == 0) && (i < 4 * n);
    end
    @(posedge clk);
    decoded_bit_valid <= 1'b0;
    norm_event        <= 1'b0;
    repeat (5) @(posedge clk);
    cmp({4'h0, sync_lost_flag, sync_held_flag}, {4'h0, lost, !lost});
    cmp({5'h00, decoded_out_q}, {5'h00, diff_enable ? rnd[30] ^ rnd[28] : rnd[30]});
  endtask
  always @(posedge clk) begin
    if (pair_valid_q === 1'b1)
      cmp({int_word0_q, int_word1_q}, exp_q.size() ? exp_q.pop_front() : 6'hx);
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #2_000_000;
    errors++;
    end_of_test;
  end
  initial begin
    {serial_mode, oqpsk_mode, use_marker, sync_step_request, norm_event, decoded_bit} = '0;
    diff_enable = 1'b0;
    {decoded_bit_valid, decoder_output_clock, periph_in_strobe, periph_out_strobe} = '0;
    {enc_ctrl2, dec_ctrl2, enc_rate_sel, dec_rate_sel, periph_word_0, periph_word_1} = '0;
    {alt, pw1, errors, checks} = '0;
    rnd   = 32'h0000_6e7d;
    reset = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    mon(53, 1'b1);
    diff_enable <= 1'b1;
    mon(52, 1'b0);
    for (int r = 0; r < 4; r++) begin
      enc_rate_sel <= r[1:0];
      dec_rate_sel <= ~r[1:0];
      par(1'b0);
    end
    step;
    repeat (4) par(1'b0);
    oqpsk_mode <= 1'b1;
    repeat (4) par(1'b1);
    step;
    oqpsk_mode <= 1'b0;
    decoder_output_clock <= 1'b1;
    repeat (3) @(posedge clk);
    decoder_output_clock <= 1'b0;
    serial_mode <= 1'b1;
    use_marker  <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      note(rnd[2:0], rnd[5:3], 1'b0);
      dm.send(rnd[2:0], ~rnd[2:0], 1'b0, 1);
      dm.send(rnd[5:3], ~rnd[5:3], 1'b1, 1);
    end
    use_marker <= 1'b0;
    // Automatic pairing: a step drops the middle word so the pair closes on the third
    for (int k = 0; k < 2; k++) begin
      rnd = lfsr(rnd);
      note(rnd[2:0], rnd[5:3], 1'b0);
      dm.send(rnd[2:0], 3'h0, 1'b1, 1);
      step;
      dm.send(~rnd[5:3], 3'h0, 1'b1, 1);
      dm.send(rnd[5:3], 3'h0, 1'b1, 1);
    end
    serial_mode <= 1'b0;
    enc_ctrl2   <= 8'h08;
    par(1'b0);
    dm.park;
    dec_ctrl2 <= 8'h08;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      note(rnd[2:0], rnd[5:3], 1'b0);
      periph_word_0 <= rnd[2:0];
      periph_word_1 <= rnd[5:3];
      @(posedge clk);
      periph_in_strobe <= 1'b1;
      @(posedge clk);
      periph_in_strobe  <= 1'b0;
      periph_out_strobe <= 1'b1;
      @(posedge clk);
      periph_out_strobe <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (10) @(posedge clk);
    cmp({5'h00, exp_q.size() == 0}, 6'h01);
    end_of_test;
  end
endmodule // vsm_sync_front_tb_top
